/* rtl/ecm_defines.svh */
// Constants for the card and flash signal multiplexer
`ifndef ECM_DEFINES_SVH
`define ECM_DEFINES_SVH
`define ECM_ADDR_W 26
`define ECM_RNW_BIT 25
`define ECM_MODE_HI 23
`define ECM_MODE_LO 21
`define ECM_ALE_BIT 21
`define ECM_CLE_BIT 22
`define ECM_CS3_BASE 32'h4000_0000
`define ECM_CS3_LAST 32'h4FFF_FFFF
`define ECM_MODE_ATTR 3'h0
`define ECM_MODE_COMMON 3'h2
`define ECM_MODE_IO 3'h4
`define ECM_MODE_IDE 3'h6
`define ECM_MODE_ALT_IDE 3'h7
`define ECM_NAND_OFF 2'h0
`define ECM_NAND_ON 2'h1
`define ECM_BOOT_DBW 2'h1
`define ECM_BOOT_BAT 1'h1
`define ECM_BOOT_CSRW 1'h1
`endif

/* rtl/ecm_pkg.sv */
// Types for the card and flash signal multiplexer
package ecm_pkg;
    typedef enum logic [2:0] {
        ECM_ACC_ATTR,
        ECM_ACC_COMMON,
        ECM_ACC_IO,
        ECM_ACC_IDE,
        ECM_ACC_ALT_IDE,
        ECM_ACC_NONE
    } ecm_access_t;

    // Strobes as produced by the static memory controller, all active low
    typedef struct packed {
        logic read_n;
        logic write0_n;
        logic write1_n;
        logic write3_n;
        logic cs3_n;
        logic cs4_n;
        logic cs5_n;
    } ecm_strobes_t;

    // Chip select zero boot configuration
    typedef struct packed {
        logic [1:0] data_width;
        logic byte_select;
        logic cs_controls_rw;
    } ecm_boot_cfg_t;
endpackage

/* rtl/ecm_signal_mux.sv */
// Pin multiplexer routing controller strobes onto card and NAND pins
`timescale 1ns/1ps
`include "ecm_defines.svh"

// Behaviour
// RL1: Assignment bit set drives card select on chip-select-4/5 pin, else ordinary select.
// RL2: Assigned card select pins must not drive any other memory device.
// RL3: During card access shared pins carry card strobes, otherwise bus signals.
// RL4: Slot 0 card select timing equals controller chip-select-4 timing.
// RL5: Card read-not-write holds stable through each transfer, like address.
// RL6: Card select and read-not-write serve as buffer enable and direction.
// RL7: Card wait request feeds controller external wait input.
// RL8: NAND glue active only when assignment field programmed; window 0x4000_0000..0x4FFF_FFFF.
// RL9: While chip select 3 active, read/write strobes copied to NAND enables.
// RL10: NAND enables deassert immediately when address leaves chip-select-3 window.
// RL11: Software uses A21 for address latch, A22 for command latch.
// RL12: NAND command, address, data told apart only by access offset.
// RL13: Host drives NAND chip enable and ready/busy via general pins.
// RL14: Software uses A23 for I/O versus memory, A22 for attribute.
// RL15: Software uses A21 to choose alternate or primary disk registers.
// RL16: After reset chip select 0 is byte-select, 16-bit, chip-select read/write.
// RL17: Software programs chip select 3 timing for NAND before access.
// RL18: Software sets general pins for card reset, interrupt, card detect.
// RL19: Address bits 23..21 select attribute, common, I/O, disk, alternate disk.
// RL20: I/O and disk modes use I/O strobes; memory modes use memory strobes.
module ecm_signal_mux
    import ecm_pkg::*;
(
    input wire logic clk_i, // System bus clock
    input wire logic reset_i, // Synchronous reset, active high
    input wire logic slot0_assign_bit_i, // Slot 0 assigned to chip select 4
    input wire logic slot1_assign_bit_i, // Slot 1 assigned to chip select 5
    input wire logic [1:0] nand_assign_field_i, // NAND assignment on chip select 3
    input wire ecm_strobes_t smc_i, // Controller strobes, active low
    input wire logic [31:0] trans_addr_i, // Current transfer address
    input wire logic [`ECM_ADDR_W-1:0] ext_addr_i, // Controller address pins
    input wire logic smc_write_i, // Current transfer is a write
    input wire logic card_wait_n_i, // Card wait request, active low
    output logic chip_select_four_o, // Pin: ordinary select or card slot 0 select
    output logic chip_select_five_o, // Pin: ordinary select or card slot 1 select
    output logic read_strobe_o, // Pin: read or card output enable
    output logic write0_or_write_enable_o, // Pin: write 0 or card write enable
    output logic write1_or_byte1_select_o, // Pin: write 1 or card I/O read
    output logic write3_or_byte3_select_o, // Pin: write 3 or card I/O write
    output logic [`ECM_ADDR_W-1:0] addr_pins_o, // Address pins, bit 25 shared
    output logic flash_output_enable_o, // NAND output enable, active low
    output logic flash_write_enable_o, // NAND write enable, active low
    output logic nand_ale_o, // Address latch enable seen on the bus
    output logic nand_cle_o, // Command latch enable seen on the bus
    output logic external_wait_input_o, // Wait to controller, active low
    output ecm_boot_cfg_t boot_cfg_o, // Chip select 0 configuration
    output ecm_access_t card_access_o // Decoded card access type
);
    logic card0_act;
    logic card1_act;
    logic card_act;
    logic io_mode;
    logic in_cs3;
    logic nand_on;
    logic rnw_r;
    logic rnw_nxt;
    ecm_access_t access;
    ecm_boot_cfg_t boot_r;

    assign card0_act = slot0_assign_bit_i && !smc_i.cs4_n;
    assign card1_act = slot1_assign_bit_i && !smc_i.cs5_n;
    assign card_act = card0_act || card1_act;

    always_comb begin
        unique case (ext_addr_i[`ECM_MODE_HI:`ECM_MODE_LO]) // RL19
            `ECM_MODE_ATTR: access = ECM_ACC_ATTR;
            `ECM_MODE_COMMON: access = ECM_ACC_COMMON;
            `ECM_MODE_IO: access = ECM_ACC_IO;
            `ECM_MODE_IDE: access = ECM_ACC_IDE;
            `ECM_MODE_ALT_IDE: access = ECM_ACC_ALT_IDE;
            default: access = ECM_ACC_NONE;
        endcase
    end
    assign card_access_o = card_act ? access : ECM_ACC_NONE;
    assign io_mode = (access == ECM_ACC_IO) || (access == ECM_ACC_IDE)
        || (access == ECM_ACC_ALT_IDE); // RL20

    // Card select is the raw controller select, so its timing matches exactly
    assign chip_select_four_o = smc_i.cs4_n; // RL1 RL4 RL6
    assign chip_select_five_o = smc_i.cs5_n; // RL1 RL6

    always_comb begin
        read_strobe_o = smc_i.read_n;
        write0_or_write_enable_o = smc_i.write0_n;
        write1_or_byte1_select_o = smc_i.write1_n;
        write3_or_byte3_select_o = smc_i.write3_n;
        if (card_act) begin // RL3
            read_strobe_o = io_mode ? 1'b1 : smc_i.read_n; // RL20
            write0_or_write_enable_o = io_mode ? 1'b1 : smc_i.write0_n; // RL20
            write1_or_byte1_select_o = io_mode ? smc_i.read_n : 1'b1; // RL20
            write3_or_byte3_select_o = io_mode ? smc_i.write0_n : 1'b1; // RL20
        end
    end

    // Direction latched while no card select is active, so it cannot move mid-transfer
    assign rnw_nxt = card_act ? rnw_r : !smc_write_i;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rnw_r <= 1'b1;
        end else begin
            rnw_r <= rnw_nxt; // RL5
        end
    end

    always_comb begin
        addr_pins_o = ext_addr_i;
        if (card_act) begin
            addr_pins_o[`ECM_RNW_BIT] = rnw_r; // RL3 RL5 RL6
        end
    end

    assign nand_on = nand_assign_field_i != `ECM_NAND_OFF; // RL8
    assign in_cs3 = (trans_addr_i >= `ECM_CS3_BASE) && (trans_addr_i <= `ECM_CS3_LAST);
    // Gated combinationally by the window so the enables drop the same cycle
    assign flash_output_enable_o = !(nand_on && in_cs3 && !smc_i.cs3_n
        && !smc_i.read_n); // RL9 RL10
    assign flash_write_enable_o = !(nand_on && in_cs3 && !smc_i.cs3_n
        && !smc_i.write0_n); // RL9 RL10
    assign nand_ale_o = ext_addr_i[`ECM_ALE_BIT]; // RL12
    assign nand_cle_o = ext_addr_i[`ECM_CLE_BIT]; // RL12

    assign external_wait_input_o = card_wait_n_i; // RL7

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            boot_r <= '{data_width: `ECM_BOOT_DBW, byte_select: `ECM_BOOT_BAT,
                cs_controls_rw: `ECM_BOOT_CSRW}; // RL16
        end else begin
            boot_r <= boot_r;
        end
    end
    assign boot_cfg_o = boot_r;

    property p_nand_oe_window;
        @(posedge clk_i) disable iff (reset_i)
            !in_cs3 |-> flash_output_enable_o && flash_write_enable_o;
    endproperty
    a_nand_oe_window: assert property (p_nand_oe_window) else $error("NAND enable outside window"); // RL10

    property p_nand_copy;
        @(posedge clk_i) disable iff (reset_i)
            nand_on && in_cs3 && !smc_i.cs3_n |-> flash_output_enable_o == smc_i.read_n;
    endproperty
    a_nand_copy: assert property (p_nand_copy) else $error("NAND output enable not copied"); // RL9

    property p_nand_off;
        @(posedge clk_i) disable iff (reset_i) !nand_on |-> flash_write_enable_o;
    endproperty
    a_nand_off: assert property (p_nand_off) else $error("NAND active while unassigned"); // RL8

    property p_cs4;
        @(posedge clk_i) disable iff (reset_i) chip_select_four_o == smc_i.cs4_n;
    endproperty
    a_cs4: assert property (p_cs4) else $error("Slot 0 select timing differs"); // RL4

    sequence s_card_hold;
        card_act ##1 card_act;
    endsequence
    property p_rnw_stable;
        @(posedge clk_i) disable iff (reset_i)
            s_card_hold |-> $stable(addr_pins_o[`ECM_RNW_BIT]);
    endproperty
    a_rnw_stable: assert property (p_rnw_stable) else $error("Read-not-write moved in transfer"); // RL5

    property p_io_strobes;
        @(posedge clk_i) disable iff (reset_i)
            card_act && io_mode |-> read_strobe_o && write1_or_byte1_select_o == smc_i.read_n;
    endproperty
    a_io_strobes: assert property (p_io_strobes) else $error("I/O strobe routing wrong"); // RL20

    property p_mem_strobes;
        @(posedge clk_i) disable iff (reset_i)
            card_act && !io_mode |-> write3_or_byte3_select_o && read_strobe_o == smc_i.read_n;
    endproperty
    a_mem_strobes: assert property (p_mem_strobes) else $error("Memory strobe routing wrong"); // RL3

    property p_wait;
        @(posedge clk_i) disable iff (reset_i) external_wait_input_o == card_wait_n_i;
    endproperty
    a_wait: assert property (p_wait) else $error("Wait not forwarded"); // RL7

    property p_boot;
        @(posedge clk_i) disable iff (reset_i) boot_cfg_o.data_width == `ECM_BOOT_DBW;
    endproperty
    a_boot: assert property (p_boot) else $error("Boot width not 16-bit"); // RL16

    property p_boot_mode;
        @(posedge clk_i) disable iff (reset_i)
            boot_cfg_o.byte_select == `ECM_BOOT_BAT && boot_cfg_o.cs_controls_rw == `ECM_BOOT_CSRW;
    endproperty
    a_boot_mode: assert property (p_boot_mode) else $error("Boot mode bits wrong"); // RL16

    property p_cs5;
        @(posedge clk_i) disable iff (reset_i)
            chip_select_five_o == smc_i.cs5_n;
    endproperty
    a_cs5: assert property (p_cs5) else $error("Slot 1 select differs"); // RL1

    property p_nand_we_copy;
        @(posedge clk_i) disable iff (reset_i)
            nand_on && in_cs3 && !smc_i.cs3_n |-> flash_write_enable_o == smc_i.write0_n;
    endproperty
    a_nand_we_copy: assert property (p_nand_we_copy) else $error("NAND write enable not copied"); // RL9

    property p_nand_cs3_idle;
        @(posedge clk_i) disable iff (reset_i)
            smc_i.cs3_n |-> flash_output_enable_o && flash_write_enable_o;
    endproperty
    a_nand_cs3_idle: assert property (p_nand_cs3_idle) else $error("NAND enable without select"); // RL9

    property p_nand_off_oe;
        @(posedge clk_i) disable iff (reset_i)
            !nand_on |-> flash_output_enable_o;
    endproperty
    a_nand_off_oe: assert property (p_nand_off_oe) else $error("NAND read while unassigned"); // RL8

    property p_io_write;
        @(posedge clk_i) disable iff (reset_i)
            card_act && io_mode |-> write0_or_write_enable_o && write3_or_byte3_select_o == smc_i.write0_n;
    endproperty
    a_io_write: assert property (p_io_write) else $error("I/O write routing wrong"); // RL20

    property p_mem_write;
        @(posedge clk_i) disable iff (reset_i)
            card_act && !io_mode |-> write1_or_byte1_select_o && write0_or_write_enable_o == smc_i.write0_n;
    endproperty
    a_mem_write: assert property (p_mem_write) else $error("Memory write routing wrong"); // RL20

    property p_shared_idle;
        @(posedge clk_i) disable iff (reset_i)
            !card_act |-> read_strobe_o == smc_i.read_n && write1_or_byte1_select_o == smc_i.write1_n;
    endproperty
    a_shared_idle: assert property (p_shared_idle) else $error("Bus strobe not passed"); // RL3

    property p_shared_idle_wr;
        @(posedge clk_i) disable iff (reset_i)
            !card_act |-> write0_or_write_enable_o == smc_i.write0_n && write3_or_byte3_select_o == smc_i.write3_n;
    endproperty
    a_shared_idle_wr: assert property (p_shared_idle_wr) else $error("Bus write not passed"); // RL3

    property p_addr_pass;
        @(posedge clk_i) disable iff (reset_i)
            addr_pins_o[`ECM_RNW_BIT-1:0] == ext_addr_i[`ECM_RNW_BIT-1:0];
    endproperty
    a_addr_pass: assert property (p_addr_pass) else $error("Address pins differ"); // RL3

    property p_a25_idle;
        @(posedge clk_i) disable iff (reset_i)
            !card_act |-> addr_pins_o[`ECM_RNW_BIT] == ext_addr_i[`ECM_RNW_BIT];
    endproperty
    a_a25_idle: assert property (p_a25_idle) else $error("Top address bit not passed"); // RL3

    // Direction shown at the start of an access is the one set up a cycle before
    sequence s_card_start;
        !card_act ##1 card_act;
    endsequence
    property p_rnw_capture;
        @(posedge clk_i) disable iff (reset_i)
            s_card_start |-> addr_pins_o[`ECM_RNW_BIT] == !$past(smc_write_i);
    endproperty
    a_rnw_capture: assert property (p_rnw_capture) else $error("Read-not-write not captured"); // RL5

    property p_access_none;
        @(posedge clk_i) disable iff (reset_i)
            !card_act |-> card_access_o == ECM_ACC_NONE;
    endproperty
    a_access_none: assert property (p_access_none) else $error("Access type without card"); // RL19

    property p_access_attr;
        @(posedge clk_i) disable iff (reset_i)
            card_act && ext_addr_i[`ECM_MODE_HI:`ECM_MODE_LO] == `ECM_MODE_ATTR |-> card_access_o == ECM_ACC_ATTR;
    endproperty
    a_access_attr: assert property (p_access_attr) else $error("Attribute decode wrong"); // RL19

    property p_access_common;
        @(posedge clk_i) disable iff (reset_i)
            card_act && ext_addr_i[`ECM_MODE_HI:`ECM_MODE_LO] == `ECM_MODE_COMMON |-> card_access_o == ECM_ACC_COMMON;
    endproperty
    a_access_common: assert property (p_access_common) else $error("Common decode wrong"); // RL19

    property p_access_io;
        @(posedge clk_i) disable iff (reset_i)
            card_act && ext_addr_i[`ECM_MODE_HI:`ECM_MODE_LO] == `ECM_MODE_IO |-> card_access_o == ECM_ACC_IO;
    endproperty
    a_access_io: assert property (p_access_io) else $error("I/O decode wrong"); // RL19

    property p_access_alt;
        @(posedge clk_i) disable iff (reset_i)
            card_act && ext_addr_i[`ECM_MODE_HI:`ECM_MODE_LO] == `ECM_MODE_ALT_IDE |-> card_access_o == ECM_ACC_ALT_IDE;
    endproperty
    a_access_alt: assert property (p_access_alt) else $error("Alternate disk decode wrong"); // RL19

    property p_latch_bits;
        @(posedge clk_i) disable iff (reset_i)
            nand_ale_o == ext_addr_i[`ECM_ALE_BIT] && nand_cle_o == ext_addr_i[`ECM_CLE_BIT];
    endproperty
    a_latch_bits: assert property (p_latch_bits) else $error("Latch enables not from offset"); // RL12
endmodule

/* test/ecm_card_model.sv */
// Far-side card slot model: answers a select with an optional wait request
`timescale 1ns/1ps
module ecm_card_model (
    input wire logic clk_i, // System clock
    input wire logic select_n_i, // Card select pin, active low
    input wire logic slow_i, // Stretch accesses with wait
    output logic card_wait_n_o // Wait request, active low
);
    logic [1:0] age_r;
    always_ff @(posedge clk_i) begin
        if (select_n_i) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    // A slow card holds wait for the first cycles of every select
    assign card_wait_n_o = !(slow_i && !select_n_i && age_r != 2'h3);
endmodule

/* test/ecm_signal_mux_bench.sv */
// Self-checking random bench for the card and flash signal multiplexer
`timescale 1ns/1ps
`include "ecm_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module ecm_signal_mux_bench;
    import ecm_pkg::*;
    logic clk_i, reset_i, slot0, slot1, wr, slow, wait_n, rnw_m, act;
    logic [1:0] field;
    ecm_strobes_t static_memory_controller;
    logic [31:0] trans;
    logic [`ECM_ADDR_W-1:0] ext, addr_o;
    logic cs4_o, cs5_o, rd_o, wr0_o, wr1_o, wr3_o, foe_o, fwe_o, ale_o, cle_o, wait_o;
    ecm_boot_cfg_t boot_o;
    ecm_access_t acc_o;
    int checked = 0;
    int fail_count = 0;
    ecm_signal_mux DUT (.clk_i(clk_i), .reset_i(reset_i), .slot0_assign_bit_i(slot0),
        .slot1_assign_bit_i(slot1), .nand_assign_field_i(field), .smc_i(static_memory_controller),
        .trans_addr_i(trans), .ext_addr_i(ext), .smc_write_i(wr), .card_wait_n_i(wait_n),
        .chip_select_four_o(cs4_o), .chip_select_five_o(cs5_o), .read_strobe_o(rd_o),
        .write0_or_write_enable_o(wr0_o), .write1_or_byte1_select_o(wr1_o),
        .write3_or_byte3_select_o(wr3_o), .addr_pins_o(addr_o), .flash_output_enable_o(foe_o),
        .flash_write_enable_o(fwe_o), .nand_ale_o(ale_o), .nand_cle_o(cle_o),
        .external_wait_input_o(wait_o), .boot_cfg_o(boot_o), .card_access_o(acc_o));
    // Only the card hangs on the dedicated select pin
    ecm_card_model card (.clk_i(clk_i), .select_n_i(cs4_o), .slow_i(slow),
        .card_wait_n_o(wait_n));
    always #50 clk_i = !clk_i;
    assign act = (slot0 && !static_memory_controller.cs4_n) || (slot1 && !static_memory_controller.cs5_n);
    // Direction is latched from the cycle before the card access starts
    always @(posedge clk_i) begin
        if (reset_i) rnw_m <= 1'b1;
        else if (!act) rnw_m <= !wr;
    end
    function automatic ecm_access_t exp_acc(input logic a, input logic [2:0] m);
        if (!a) return ECM_ACC_NONE;
        case (m)
            `ECM_MODE_ATTR: return ECM_ACC_ATTR;
            `ECM_MODE_COMMON: return ECM_ACC_COMMON;
            `ECM_MODE_IO: return ECM_ACC_IO;
            `ECM_MODE_IDE: return ECM_ACC_IDE;
            `ECM_MODE_ALT_IDE: return ECM_ACC_ALT_IDE;
            default: return ECM_ACC_NONE;
        endcase
    endfunction
    task automatic check_pins();
        logic io, nand_on;
        logic [2:0] m;
        ecm_boot_cfg_t boot_e;
        m = ext[23:21];
        io = act && (m == `ECM_MODE_IO || m == `ECM_MODE_IDE || m == `ECM_MODE_ALT_IDE);
        nand_on = field != 2'h0 && !static_memory_controller.cs3_n && trans >= `ECM_CS3_BASE && trans <= `ECM_CS3_LAST;
        boot_e = '{data_width: `ECM_BOOT_DBW, byte_select: `ECM_BOOT_BAT,
            cs_controls_rw: `ECM_BOOT_CSRW};
        `CHK("cs4", static_memory_controller.cs4_n, cs4_o)
        `CHK("cs5", static_memory_controller.cs5_n, cs5_o)
        `CHK("rd", io ? 1'b1 : static_memory_controller.read_n, rd_o)
        `CHK("wr0", io ? 1'b1 : static_memory_controller.write0_n, wr0_o)
        `CHK("wr1", !act ? static_memory_controller.write1_n : (io ? static_memory_controller.read_n : 1'b1), wr1_o)
        `CHK("wr3", !act ? static_memory_controller.write3_n : (io ? static_memory_controller.write0_n : 1'b1), wr3_o)
        `CHK("a25", act ? rnw_m : ext[25], addr_o[25])
        `CHK("addr", ext[24:0], addr_o[24:0])
        `CHK("noe", nand_on ? static_memory_controller.read_n : 1'b1, foe_o)
        `CHK("nwe", nand_on ? static_memory_controller.write0_n : 1'b1, fwe_o)
        `CHK("ale", ext[`ECM_ALE_BIT], ale_o)
        `CHK("cle", ext[`ECM_CLE_BIT], cle_o)
        `CHK("wait", wait_n, wait_o)
        `CHK("boot", boot_e, boot_o)
        `CHK("acc", exp_acc(act, m), acc_o)
    endtask
    always @(negedge clk_i) begin
        if (!reset_i) check_pins();
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        int sel;
        logic [31:0] a;
        clk_i = 0; reset_i = 1; slot0 = 0; slot1 = 0; field = 0; static_memory_controller = '1;
        trans = 0; ext = 0; wr = 0; slow = 0;
        void'($urandom(82));
        repeat (10) @(posedge clk_i);
        reset_i <= 0;
        for (int t = 0; t < 600; t++) begin
            @(posedge clk_i);
            sel = $urandom % 3;
            // Latch bits and plain data keep offsets apart; edges probe the flash window
            a = {4'h4 + 4'(sel), 28'($urandom)};
            if (sel == 0 && t % 5 == 0) a = (t % 10 == 0) ? 32'h3FFF_FFFF : 32'h5000_0000;
            static_memory_controller <= '1; // Direction settles a cycle before the select falls
            wr <= 1'($urandom); slot0 <= 1'($urandom); slot1 <= 1'($urandom);
            field <= 2'($urandom); slow <= 1'($urandom);
            trans <= a; ext <= a[25:0];
            repeat (1 + $urandom % 4) begin
                @(posedge clk_i);
                static_memory_controller <= ecm_strobes_t'({4'($urandom), sel != 0, sel != 1, sel != 2});
            end
        end
        @(posedge clk_i);
        summarize();
    end
endmodule
